// *** rtl/radio_test_defines.svh ***
// Register map, command codes and timing counts of the test sequencer.
// Assumes a 10 MHz core clock; included by both rtl module files.
`ifndef RADIO_TEST_DEFINES_SVH
`define RADIO_TEST_DEFINES_SVH

// Register offsets
`define REG_STATE_STATUS    6'h01
`define REG_STATE_COMMAND   6'h02
`define REG_CLOCK_OUTPUT    6'h03
`define REG_MODULATION      6'h0C
`define REG_IRQ_MASK        6'h0E
`define REG_IRQ_FLAGS       6'h0F
`define REG_UNLOCK_KEY      6'h1C
`define REG_TEST_ENABLE     6'h36

// Reset values
`define RST_CLOCK_OUTPUT    8'h19
`define RST_MODULATION      8'h24
`define RST_IRQ_MASK        8'h00
`define RST_UNLOCK_KEY      8'h07
`define RST_TEST_ENABLE     8'h00
`define RST_COMMAND         5'h00

// State command field codes
`define CMD_TX_START        5'h02
`define CMD_FORCE_OFF       5'h03
`define CMD_PLL_ON          5'h09

// State status codes
`define STS_OFF             5'h08
`define STS_PLL_ON          5'h09
`define STS_BUSY_TX         5'h02

// Interrupt flag bits
`define IRQ_LOCK_BIT        0
`define IRQ_UNLOCK_BIT      1

// Test mode keys
`define TEST_ENABLE_VALUE   8'h0F
`define KEY_STEP_TWO        8'h54
`define KEY_STEP_THREE      8'h46
`define KEY_DISABLE         8'h00

// Modulation select values for carrier mode and carrier payloads
`define MOD_CARRIER_100     8'h0A
`define MOD_CARRIER_250     8'h0E
`define CARRIER_NEGATIVE    8'h00
`define CARRIER_POSITIVE    8'hFF

// Serial command prefixes
`define SPI_REG_READ        2'b10
`define SPI_REG_WRITE       2'b11
`define SPI_FB_WRITE        3'b011

// Frame layout
`define FB_DEPTH            128
`define PREAMBLE_SYMBOLS    2'd2
`define LENGTH_MSB          6

// Clock output control
`define CLKOUT_FIELD_MSB    2
`define CLKOUT_1MHZ         3'h1

// Timing
`define CLK_MHZ             10
`define RESET_PULSE_NS      625
`define RESET_PULSE_CYCLES  ((`RESET_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define PLL_SETTLE_NS       2000
`define PLL_SETTLE_CYCLES   ((`PLL_SETTLE_NS * `CLK_MHZ) / 1000)
`define SYMBOL_NS           1600
`define SYMBOL_CYCLES       ((`SYMBOL_NS * `CLK_MHZ) / 1000)
`define CLKOUT_HALF_CYCLES  (`CLK_MHZ / 2)

`endif

// *** rtl/radio_test_pkg.sv ***
// Types shared by the test sequencer and its serial port.
// Assumes nothing beyond the defines header.
package radio_test_pkg;

  typedef enum logic [1:0] {
    transceiver_off_state = 2'b00,
    pll_on  = 2'b01,
    busy_tx = 2'b11
  } radio_state_t;

  typedef enum logic [2:0] {
    carrier_none    = 3'h0,
    carrier_pos_250 = 3'h1,
    carrier_neg_250 = 3'h2,
    carrier_pos_100 = 3'h3,
    carrier_neg_100 = 3'h4
  } carrier_t;

  typedef struct packed {
    logic     sclk;
    logic     mosi;
    logic     sel_n;
  } spi_pins_t;

  typedef struct packed {
    logic     active;
    carrier_t carrier;
    logic     strobe;
    logic [7:0] data;
  } tx_stream_t;

endpackage : radio_test_pkg

// *** rtl/spi_byte_port.sv ***
// Serial slave byte port, mode 0, MSB first.
// Assumes pins from the host domain; sclk far slower than clk.
`timescale 1ns/100ps
`include "radio_test_defines.svh"
module spi_byte_port
  import radio_test_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pins
  input  wire spi_pins_t  pins,
  output logic            miso,
  output logic            miso_oe,
  // Byte side
  input  wire logic [7:0] tx_data,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            frame_start
);

  spi_pins_t  sync1, sync2, sync3;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] next_rx_data;
  logic       next_rx_valid;
  logic       sel_act, rise, fall;

  assign sel_act     = ~sync2.sel_n;
  assign rise        = sync2.sclk & ~sync3.sclk;
  assign fall        = ~sync2.sclk & sync3.sclk;
  assign frame_start = sel_act & sync3.sel_n;
  assign miso        = shift_out[7];
  assign miso_oe     = sel_act;

  always_comb begin
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt   = bit_cnt;
    next_rx_data   = rx_data;
    next_rx_valid  = 1'b0;
    if (!sel_act || frame_start) begin
      next_bit_cnt   = 3'h0;
      next_shift_out = 8'h00;
    end else if (rise) begin
      next_shift_in = {shift_in[6:0], sync2.mosi};
      next_bit_cnt  = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_rx_data  = {shift_in[6:0], sync2.mosi};
        next_rx_valid = 1'b1;
      end
    end else if (fall) begin
      // Reply is loaded only after a full byte, so the core has time
      if (bit_cnt == 3'h0) begin
        next_shift_out = tx_data;
      end else begin
        next_shift_out = {shift_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1     <= '{sclk: 1'b0, mosi: 1'b0, sel_n: 1'b1};
      sync2     <= '{sclk: 1'b0, mosi: 1'b0, sel_n: 1'b1};
      sync3     <= '{sclk: 1'b0, mosi: 1'b0, sel_n: 1'b1};
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt   <= 3'h0;
      rx_data   <= 8'h00;
      rx_valid  <= 1'b0;
    end else begin
      sync1     <= pins;
      sync2     <= sync1;
      sync3     <= sync2;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt   <= next_bit_cnt;
      rx_data   <= next_rx_data;
      rx_valid  <= next_rx_valid;
    end
  end

endmodule : spi_byte_port

// *** rtl/continuous_tx_test_sequence.sv ***
// Radio core register file, state control and continuous test transmitter.
// Assumes a host on the serial port and reset pin; pins are asynchronous.
//
// Contract
// (RQ1) Carrier mode sends plus or minus 0.25 or 0.1 MHz, never centre.
// (RQ2) Two non-payload symbols, then payload repeats until test mode ends.
// (RQ3) Host loads length 0x01..0x7F then payload into frame buffer.
// (RQ4) Test mode armed via 0x36 and 0x1C; tx after pll on plus start.
// (RQ5) Host writes 0x01 to mask register 0x0E after reset.
// (RQ6) Host writes 0x03 to 0x02 for off state, then channel, power.
// (RQ7) Host sets transmit gain offset to 2 for carrier mode.
// (RQ8) Status 0x01 reads 0x08 in the transceiver off state.
// (RQ9) Enable order: 0x0F to 0x36, mode and buffer, 0x54, 0x46 to 0x1C.
// (RQ10) Register 0x0C value selects modulation or carrier offset.
// (RQ11) Carrier payload 0x00 gives negative, 0xFF positive offset.
// (RQ12) 0x09 to 0x02 starts synthesizer; 0x0F reads 0x01 on lock.
// (RQ13) 0x02 to 0x02 starts transmitting, busy-transmit state.
// (RQ14) Host leaves test mode writing 0x00 to 0x1C, then full reset.
// (RQ15) Host sets pins idle after power, waits 400 us.
// (RQ16) Host holds reset pin low at least 625 ns.
// (RQ17) Host sets clock output 1 MHz via 0x03, then forces off state.
// (RQ18) Host ignores clock output until the clock rate write is done.
// (RQ19) Register 0x02 holds command in bits 4..0, status in 7..5; bits 7..5 read 0 here.
// (RQ20) Flags 0x0F: bit 0 lock, bit 1 unlock; mask 0x0E same bits.
// (RQ21) Host completes each serial transaction before the next.
`timescale 1ns/100ps
`include "radio_test_defines.svh"
module continuous_tx_test_sequence
  import radio_test_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Host pins
  input  wire spi_pins_t  spi_pins,
  input  wire logic       reset_pin_n,
  output logic            miso,
  output logic            miso_oe,
  // Clock output
  output logic            clock_output_pin,
  // Transmit stream
  output tx_stream_t      tx_stream
);

  localparam int RESET_CYC = `RESET_PULSE_CYCLES;
  localparam int SETTLE_CYC = `PLL_SETTLE_CYCLES;
  localparam int SYMBOL_CYC = `SYMBOL_CYCLES;
  localparam int CLKOUT_CYC = `CLKOUT_HALF_CYCLES;

  logic [7:0]   rx_data, reply;
  logic         rx_valid, frame_start;
  logic [7:0]   frame_buffer [`FB_DEPTH];
  logic         fb_we;
  logic [6:0]   fb_addr;

  radio_state_t state, next_state;
  logic [4:0]   command, next_command;
  logic [7:0]   clkout_ctrl, next_clkout_ctrl;
  logic [7:0]   modulation, next_modulation;
  logic [7:0]   irq_mask, next_irq_mask;
  logic [7:0]   irq_flags, next_irq_flags;
  logic [7:0]   unlock_key, next_unlock_key;
  logic [7:0]   test_enable, next_test_enable;
  logic         key_step, next_key_step;
  logic         test_armed, next_test_armed;
  logic [7:0]   spi_cmd, next_spi_cmd;
  logic [7:0]   byte_cnt, next_byte_cnt;
  logic [7:0]   settle_cnt, next_settle_cnt;
  logic [7:0]   symbol_cnt, next_symbol_cnt;
  logic [1:0]   preamble_cnt, next_preamble_cnt;
  logic [6:0]   tx_idx, next_tx_idx;
  tx_stream_t   next_tx_stream;
  logic         rpin_s1, rpin_s2;
  logic [3:0]   rst_low_cnt, next_rst_low_cnt;
  logic         soft_rst;
  logic [3:0]   clkout_cnt, next_clkout_cnt;
  logic         next_clock_output;

  spi_byte_port u_port (
    .clk         (clk),
    .rst         (rst),
    .pins        (spi_pins),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .tx_data     (reply),
    .rx_data     (rx_data),
    .rx_valid    (rx_valid),
    .frame_start (frame_start)
  );

  function automatic logic [4:0] state_code(input radio_state_t s);
    unique case (s)
      transceiver_off_state: state_code = `STS_OFF;
      pll_on:  state_code = `STS_PLL_ON;
      busy_tx: state_code = `STS_BUSY_TX;
      default: state_code = `STS_OFF;
    endcase
  endfunction : state_code

  always_comb begin
    unique case (spi_cmd[5:0])
      `REG_STATE_STATUS:  reply = {3'h0, state_code(state)};  // [RQ8]
      `REG_STATE_COMMAND: reply = {3'h0, command};            // [RQ19]
      `REG_CLOCK_OUTPUT:  reply = clkout_ctrl;
      `REG_MODULATION:    reply = modulation;
      `REG_IRQ_MASK:      reply = irq_mask;
      `REG_IRQ_FLAGS:     reply = irq_flags;                  // [RQ20]
      `REG_UNLOCK_KEY:    reply = unlock_key;
      `REG_TEST_ENABLE:   reply = test_enable;
      default:            reply = 8'h00;
    endcase
  end

  // Frame buffer: bytes after the command byte, index 0 holds the length
  assign fb_addr = 7'(byte_cnt - 8'h01);
  assign fb_we   = rx_valid && (byte_cnt != 8'h00)
                   && (byte_cnt <= 8'(`FB_DEPTH))
                   && (spi_cmd[7:5] == `SPI_FB_WRITE);       // [RQ3]

  always_ff @(posedge clk) begin
    if (fb_we) begin
      frame_buffer[fb_addr] <= rx_data;
    end
  end

  // Reset pin sampled; a short glitch does not clear the registers
  assign next_rst_low_cnt = rpin_s2 ? 4'h0 :
      ((rst_low_cnt < 4'(RESET_CYC)) ? rst_low_cnt + 4'h1 : rst_low_cnt);
  assign soft_rst = (rst_low_cnt >= 4'(RESET_CYC));         // [RQ16]

  always_comb begin
    logic       wr, rd_flags;
    logic [6:0] len;
    logic [7:0] sel;
    wr  = rx_valid && (byte_cnt == 8'h01)
          && (spi_cmd[7:6] == `SPI_REG_WRITE);
    // Cleared once the reply byte is out, not when the command lands
    rd_flags = rx_valid && (byte_cnt == 8'h01)
          && (spi_cmd[7:6] == `SPI_REG_READ)
          && (spi_cmd[5:0] == `REG_IRQ_FLAGS);
    len = frame_buffer[0][`LENGTH_MSB:0];
    sel = frame_buffer[1];
    next_state        = state;
    next_command      = command;
    next_clkout_ctrl  = clkout_ctrl;
    next_modulation   = modulation;
    next_irq_mask     = irq_mask;
    next_irq_flags    = rd_flags ? 8'h00 : irq_flags;
    next_unlock_key   = unlock_key;
    next_test_enable  = test_enable;
    next_key_step     = key_step;
    next_test_armed   = test_armed;
    next_settle_cnt   = settle_cnt;
    next_symbol_cnt   = symbol_cnt;
    next_preamble_cnt = preamble_cnt;
    next_tx_idx       = tx_idx;
    next_tx_stream    = tx_stream;
    next_tx_stream.strobe = 1'b0;
    next_spi_cmd      = spi_cmd;
    next_byte_cnt     = byte_cnt;

    if (frame_start) begin
      next_byte_cnt = 8'h00;
    end else if (rx_valid) begin
      if (byte_cnt == 8'h00) begin
        next_spi_cmd = rx_data;
      end
      if (byte_cnt != 8'hFF) begin
        next_byte_cnt = byte_cnt + 8'h01;
      end
    end

    if (wr) begin
      unique case (spi_cmd[5:0])
        `REG_STATE_COMMAND: begin
          next_command = rx_data[4:0];                        // [RQ19]
          if (rx_data[4:0] == `CMD_FORCE_OFF) begin
            next_state      = transceiver_off_state;
            next_settle_cnt = 8'h00;
          end else if (rx_data[4:0] == `CMD_PLL_ON
                       && state == transceiver_off_state) begin
            next_state      = pll_on;                         // [RQ12]
            next_settle_cnt = 8'(SETTLE_CYC);
          end else if (rx_data[4:0] == `CMD_TX_START
                       && state == pll_on && settle_cnt == 8'h00) begin
            next_state        = busy_tx;                      // [RQ13]
            next_preamble_cnt = `PREAMBLE_SYMBOLS;
            next_symbol_cnt   = 8'(SYMBOL_CYC);
            next_tx_idx       = 7'h01;
          end
        end
        `REG_CLOCK_OUTPUT: next_clkout_ctrl = rx_data;
        `REG_MODULATION:   next_modulation  = rx_data;        // [RQ10]
        `REG_IRQ_MASK:     next_irq_mask    = rx_data;        // [RQ20]
        `REG_TEST_ENABLE:  next_test_enable = rx_data;
        `REG_UNLOCK_KEY: begin
          next_unlock_key = rx_data;
          next_key_step   = (rx_data == `KEY_STEP_TWO)
                            && (test_enable == `TEST_ENABLE_VALUE);
          if (rx_data == `KEY_STEP_THREE && key_step) begin
            next_test_armed = 1'b1;                           // [RQ4]
          end else if (rx_data == `KEY_DISABLE) begin
            next_test_armed = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Lock flag is sticky; a lock in the clearing cycle still sets it
    if (state == pll_on && settle_cnt != 8'h00 && next_state == pll_on) begin
      next_settle_cnt = settle_cnt - 8'h01;
      if (settle_cnt == 8'h01) begin
        next_irq_flags[`IRQ_LOCK_BIT] = 1'b1;                 // [RQ12]
      end
    end
    if (state != transceiver_off_state && next_state == transceiver_off_state) begin
      next_irq_flags[`IRQ_UNLOCK_BIT] = 1'b1;                 // [RQ20]
    end

    // Transmitter, one symbol per symbol period
    if (state == busy_tx && next_state == busy_tx) begin
      if (symbol_cnt == 8'h01) begin
        next_symbol_cnt       = 8'(SYMBOL_CYC);
        next_tx_stream.strobe = 1'b1;
        if (preamble_cnt != 2'd0) begin
          next_preamble_cnt   = preamble_cnt - 2'd1;          // [RQ2]
          next_tx_stream.data = 8'h00;
        end else if (tx_idx == 7'h00) begin
          // Index 0 marks a finished single frame; last byte had its slot
          next_state = pll_on;                                // [RQ2]
        end else begin
          next_tx_stream.data = frame_buffer[tx_idx];
          if (tx_idx >= len) begin
            // Without the test mode a frame goes out once
            next_tx_idx = test_armed ? 7'h01 : 7'h00;         // [RQ2]
          end else begin
            next_tx_idx = tx_idx + 7'h01;
          end
        end
      end else begin
        next_symbol_cnt = symbol_cnt - 8'h01;
      end
    end

    next_tx_stream.active  = (next_state == busy_tx);
    // Tone latched at start, so a disarm or mode write cannot retune it
    if (next_state != busy_tx || state != busy_tx) begin
      next_tx_stream.carrier = carrier_none;
    end
    if (next_state == busy_tx && state != busy_tx
        && test_armed) begin                                  // [RQ1]
      if (modulation == `MOD_CARRIER_250) begin
        next_tx_stream.carrier = (sel == `CARRIER_POSITIVE) ?
            carrier_pos_250 : carrier_neg_250;                // [RQ11]
      end else if (modulation == `MOD_CARRIER_100) begin
        next_tx_stream.carrier = (sel == `CARRIER_POSITIVE) ?
            carrier_pos_100 : carrier_neg_100;                // [RQ11]
      end
    end
    if (!next_tx_stream.active) begin
      next_tx_stream.strobe = 1'b0;
    end

    if (soft_rst) begin
      next_state       = transceiver_off_state;
      next_command     = `RST_COMMAND;
      next_clkout_ctrl = `RST_CLOCK_OUTPUT;
      next_modulation  = `RST_MODULATION;
      next_irq_mask    = `RST_IRQ_MASK;
      next_irq_flags   = 8'h00;
      next_unlock_key  = `RST_UNLOCK_KEY;
      next_test_enable = `RST_TEST_ENABLE;
      next_key_step    = 1'b0;
      next_test_armed  = 1'b0;                                // [RQ14]
      next_tx_stream   = '0;
    end
  end

  // Clock output divider; only the 1 MHz rate is produced
  always_comb begin
    next_clkout_cnt   = clkout_cnt;
    next_clock_output = clock_output_pin;
    if (clkout_ctrl[`CLKOUT_FIELD_MSB:0] != `CLKOUT_1MHZ) begin
      next_clkout_cnt   = 4'h0;
      next_clock_output = 1'b0;
    end else if (clkout_cnt == 4'(CLKOUT_CYC - 1)) begin
      next_clkout_cnt   = 4'h0;
      next_clock_output = ~clock_output_pin;                  // [RQ17]
    end else begin
      next_clkout_cnt = clkout_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= transceiver_off_state;
      command          <= `RST_COMMAND;
      clkout_ctrl      <= `RST_CLOCK_OUTPUT;
      modulation       <= `RST_MODULATION;
      irq_mask         <= `RST_IRQ_MASK;
      irq_flags        <= 8'h00;
      unlock_key       <= `RST_UNLOCK_KEY;
      test_enable      <= `RST_TEST_ENABLE;
      key_step         <= 1'b0;
      test_armed       <= 1'b0;
      spi_cmd          <= 8'h00;
      byte_cnt         <= 8'h00;
      settle_cnt       <= 8'h00;
      symbol_cnt       <= 8'h00;
      preamble_cnt     <= 2'd0;
      tx_idx           <= 7'h01;
      tx_stream        <= '0;
      rpin_s1          <= 1'b1;
      rpin_s2          <= 1'b1;
      rst_low_cnt      <= 4'h0;
      clkout_cnt       <= 4'h0;
      clock_output_pin <= 1'b0;
    end else begin
      state            <= next_state;
      command          <= next_command;
      clkout_ctrl      <= next_clkout_ctrl;
      modulation       <= next_modulation;
      irq_mask         <= next_irq_mask;
      irq_flags        <= next_irq_flags;
      unlock_key       <= next_unlock_key;
      test_enable      <= next_test_enable;
      key_step         <= next_key_step;
      test_armed       <= next_test_armed;
      spi_cmd          <= next_spi_cmd;
      byte_cnt         <= next_byte_cnt;
      settle_cnt       <= next_settle_cnt;
      symbol_cnt       <= next_symbol_cnt;
      preamble_cnt     <= next_preamble_cnt;
      tx_idx           <= next_tx_idx;
      tx_stream        <= next_tx_stream;
      rpin_s1          <= reset_pin_n;
      rpin_s2          <= rpin_s1;
      rst_low_cnt      <= next_rst_low_cnt;
      clkout_cnt       <= next_clkout_cnt;
      clock_output_pin <= next_clock_output;
    end
  end

endmodule : continuous_tx_test_sequence

// *** tb/ctts_chk.sv ***
// Port checker for the continuous transmit test sequencer.
// Assumes it is bound to the top module of the design.
`timescale 1ns/100ps
module ctts_chk
  import radio_test_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Host pins
  input wire spi_pins_t  spi_pins,
  input wire logic       reset_pin_n,
  input wire logic       miso,
  input wire logic       miso_oe,
  // Outputs
  input wire logic       clock_output_pin,
  input wire tx_stream_t tx_stream
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  oe_rise_a: assert property ($fell(spi_pins.sel_n) |-> ##[1:4] miso_oe)
    else $error("select did not enable the data output");
  oe_drop_a: assert property ($rose(spi_pins.sel_n) |-> ##[1:4] !miso_oe)
    else $error("deselect did not release the data output");
  lead_symbols_a: assert property ($rose(tx_stream.active) |-> ##16
    (tx_stream.strobe && tx_stream.data == 8'h00) ##16
    (tx_stream.strobe && tx_stream.data == 8'h00))
    else $error("lead symbols missing or wrong");
  strobe_gap_a: assert property (tx_stream.strobe |=> (!tx_stream.strobe)[*8])
    else $error("symbol strobes too close");
  symbol_rate_a: assert property (tx_stream.strobe |->
    ##16 (tx_stream.strobe || !tx_stream.active))
    else $error("symbol stream stalled while active");
  strobe_active_a: assert property (tx_stream.strobe |-> tx_stream.active)
    else $error("symbol strobe outside transmission");
  carrier_hold_a: assert property (tx_stream.active && $past(tx_stream.active)
    |-> $stable(tx_stream.carrier))
    else $error("carrier changed during transmission");
  clkout_shape_a: assert property (disable iff (rst || !reset_pin_n)
    $rose(clock_output_pin) |-> clock_output_pin[*5] ##1 (!clock_output_pin)[*5])
    else $error("clock output not a 1 MHz square");
endmodule : ctts_chk

// *** tb/host_model.sv ***
// Host controller model: serial master and reset pin driver.
// Assumes a 10 MHz clk; serial clock period is 8 clk cycles.
`timescale 1ns/100ps
module host_model
  import radio_test_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Device pins
  output spi_pins_t spi_pins,
  output logic      reset_pin_n,
  input  wire logic miso
);
  initial begin
    spi_pins    = '{sclk: 1'b0, mosi: 1'b0, sel_n: 1'b1};
    reset_pin_n = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // One whole transaction; select released between them
  task automatic frame(input logic [7:0] b [$], output logic [7:0] rx);
    spi_pins.sel_n = 1'b0;
    half();
    foreach (b[j]) begin
      for (int i = 7; i >= 0; i--) begin
        spi_pins.mosi = b[j][i];
        half();
        rx[i] = miso;
        spi_pins.sclk = 1'b1;
        half();
        spi_pins.sclk = 1'b0;
      end
    end
    half();
    spi_pins.sel_n = 1'b1;
    spi_pins.mosi  = ~spi_pins.mosi;
    repeat (2) half();
  endtask : frame
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] rx;
    frame('{{2'b11, a}, d}, rx);
  endtask : reg_wr
  task automatic reg_rd(input logic [5:0] a, output logic [7:0] rx);
    frame('{{2'b10, a}, 8'h00}, rx);
  endtask : reg_rd
  // Ten cycles: comfortably past the 625 ns minimum
  task automatic pin_reset();
    reset_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask : pin_reset
  // Clock output is checked by the bench throughout, except while the reset pin is low
  task automatic power_up();
    repeat (4000) @(negedge clk);
    pin_reset();
    reg_wr(6'h03, 8'h19);
    reg_wr(6'h02, 8'h03);
  endtask : power_up
endmodule : host_model

// *** tb/continuous_tx_test_sequence_tb.sv ***
// Self-checking bench for the continuous transmit test sequencer.
// Assumes the host model drives all serial and reset pins.
`timescale 1ns/100ps
module continuous_tx_test_sequence_tb;
  import radio_test_pkg::*;
  logic       clk, rst, miso, miso_oe, clock_output_pin, reset_pin_n;
  spi_pins_t  spi_pins;
  tx_stream_t tx_stream;
  int         mismatches, n_compared, len;
  logic [7:0] rx;
  logic [7:0] pay [$];
  logic [5:0] ra [7] = '{6'h01, 6'h02, 6'h03, 6'h0C, 6'h0E, 6'h1C, 6'h36};
  logic [7:0] rv [7] = '{8'h08, 8'h03, 8'h19, 8'h24, 8'h00, 8'h07, 8'h00};
  logic [7:0] md [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C,
                         8'h0A, 8'h0A, 8'h0E, 8'h0E};

  continuous_tx_test_sequence u_dut (.clk(clk), .rst(rst),
    .spi_pins(spi_pins), .reset_pin_n(reset_pin_n), .miso(miso),
    .miso_oe(miso_oe), .clock_output_pin(clock_output_pin),
    .tx_stream(tx_stream));
  host_model u_host (.clk(clk), .spi_pins(spi_pins),
    .reset_pin_n(reset_pin_n), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    u_host.reg_rd(a, rx);
    check(rx, e);
  endtask : rd
  // Centre unless mode is 0x0A or 0x0E: sign from payload, offset from the mode
  function automatic carrier_t exp_car(logic [7:0] m, logic [7:0] p);
    if (m == 8'h0E) return (p == 8'hFF) ? carrier_pos_250 : carrier_neg_250;
    if (m == 8'h0A) return (p == 8'hFF) ? carrier_pos_100 : carrier_neg_100;
    return carrier_none;
  endfunction : exp_car
  task automatic capture(input int n, input logic [7:0] m);
    int k = 0;
    int t = 0;
    while (k < n && t < 16 * n + 400) begin
      @(posedge clk);
      #1;
      t++;
      if (tx_stream.strobe === 1'b1) begin
        check(tx_stream.data, k < 2 ? 8'h00 : pay[(k - 2) % len]);
        check(tx_stream.carrier, exp_car(m, pay[0]));
        k++;
      end
    end
    if (k < n) begin
      mismatches++;
      summarize();
    end
  endtask : capture
  task automatic run(input logic [7:0] m, input bit arm, input int n);
    logic [7:0] f [$];
    int t = 0;
    f = {8'h60, 8'(len), pay};
    u_host.reg_wr(6'h0E, 8'h01);
    u_host.reg_wr(6'h02, 8'h02);
    if (m == 8'h0A || m == 8'h0E) u_host.reg_wr(6'h16, 8'h32);
    rd(6'h01, 8'h08);
    u_host.reg_wr(6'h36, 8'h0F);
    u_host.reg_wr(6'h0C, m);
    rd(6'h0C, m);
    u_host.frame(f, rx);
    if (arm) u_host.reg_wr(6'h1C, 8'h54);
    u_host.reg_wr(6'h1C, 8'h46);
    u_host.reg_rd(6'h0F, rx);
    u_host.reg_wr(6'h02, 8'h09);
    do begin
      u_host.reg_rd(6'h0F, rx);
      t++;
    end while (rx === 8'h00 && t < 8);
    check(rx, 8'h01);
    rd(6'h01, 8'h09);
    fork
      capture(n, m);
      u_host.reg_wr(6'h02, 8'h02);
    join
    rd(6'h01, arm ? 8'h02 : 8'h09);
    check(tx_stream.active, arm);
    u_host.reg_wr(6'h1C, 8'h00);
    u_host.pin_reset();
    rd(6'h01, 8'h08);
  endtask : run

  initial begin
    rst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(41));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(tx_stream, '0);
    u_host.power_up();
    foreach (ra[i]) rd(ra[i], rv[i]);
    u_host.reg_wr(6'h3F, 8'($urandom));
    rd(6'h3F, 8'h00);
    foreach (md[i]) begin
      len = (i == 0) ? 127 : 1 + $urandom % 3;
      pay = {};
      if (i > 4) pay = {(i % 2) ? 8'h00 : 8'hFF};
      else repeat (len) pay.push_back(8'($urandom));
      len = pay.size();
      run(md[i], i != 4, (i == 4) ? 2 + len : 2 + 2 * len + 1);
    end
    summarize();
  end
endmodule : continuous_tx_test_sequence_tb

bind continuous_tx_test_sequence ctts_chk u_chk (.clk(clk), .rst(rst),
  .spi_pins(spi_pins), .reset_pin_n(reset_pin_n), .miso(miso),
  .miso_oe(miso_oe), .clock_output_pin(clock_output_pin),
  .tx_stream(tx_stream));
